// file: ssp_master_model.sv
// Behavioural synchronous master that supplies the shift clock to the slave port
`timescale 1ns/10ps
`default_nettype none
module ssp_master_model (
   output logic sync_clock_line,
   output logic data_drive,
   input wire logic data_wire
);
   initial
   begin
      sync_clock_line = 1'b1;
      data_drive = 1'b1;
   end
   // Clock stands high between words; released data shows the inverse level so a stale bit cannot pass
   task automatic send_word(input logic [8:0] w, input int n);
      for (int i = 0; i < n; i++)
      begin
         data_drive = w[i];
         #100 sync_clock_line = 1'b0;
         #100 sync_clock_line = 1'b1;
      end
      data_drive = ~data_drive;
   endtask : send_word
   // Sample just before each falling edge, since the slave advances on the fall
   task automatic recv_word(input int n, output logic [8:0] w);
      w = '0;
      for (int i = 0; i < n; i++)
      begin
         #100 w[i] = data_wire;
         sync_clock_line = 1'b0;
         #100 sync_clock_line = 1'b1;
      end
   endtask : recv_word
endmodule : ssp_master_model
`default_nettype wire

// file: ssp_pkg.sv
// Constants and types for the synchronous slave serial port
package ssp_pkg;
   localparam logic [2:0] OFS_TX_CTL = 3'h0;
   localparam logic [2:0] OFS_RX_CTL = 3'h1;
   localparam logic [2:0] OFS_TX_BUF = 3'h2;
   localparam logic [2:0] OFS_RX_BUF = 3'h3;
   localparam logic [2:0] OFS_BAUD = 3'h4;
   localparam logic [2:0] OFS_FLAGS = 3'h5;
   localparam logic [2:0] OFS_ENABLES = 3'h6;
   localparam logic [2:0] OFS_PRIO = 3'h7;
   // Transmit control and status fields
   localparam int TX_CLK_SRC_B = 7;
   localparam int TX_NINE_B = 6;
   localparam int TX_EN_B = 5;
   localparam int TX_SYNC_B = 4;
   localparam int TX_HIGH_BAUD_B = 2;
   localparam int TX_SH_EMPTY_B = 1;
   localparam int TX_NINTH_B = 0;
   // Receive control and status fields
   localparam int RX_PORT_EN_B = 7;
   localparam int RX_NINE_B = 6;
   localparam int RX_SINGLE_B = 5;
   localparam int RX_CONT_B = 4;
   localparam int RX_ADDR_DET_B = 3;
   localparam int RX_FRAME_ERR_B = 2;
   localparam int RX_OVERRUN_B = 1;
   localparam int RX_NINTH_B = 0;
   // Flag, enable and priority fields
   localparam int IRQ_RX_B = 5;
   localparam int IRQ_TX_B = 4;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] WORD_BITS_8 = 4'h8;
   localparam logic [3:0] WORD_BITS_9 = 4'h9;
   typedef struct packed {
      logic clock_source_select;
      logic tx_nine_bit_select;
      logic tx_enable;
      logic sync_mode;
      logic high_baud_select;
      logic tx_ninth_bit;
   } ssp_txctl_t;
   localparam ssp_txctl_t RST_TXCTL = '0;
   typedef struct packed {
      logic port_enable;
      logic rx_nine_bit_select;
      logic single_rx_enable;
      logic continuous_rx_enable;
      logic address_detect_enable;
   } ssp_rxctl_t;
   localparam ssp_rxctl_t RST_RXCTL = '0;
   typedef enum logic [1:0] {
      SSP_TX_IDLE = 2'b01,
      SSP_TX_SHIFT = 2'b10
   } ssp_tx_state_t;
endpackage : ssp_pkg

// file: ssp_slave.sv
// Synchronous slave serial port: registers, transmit and receive shifters
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module ssp_slave #(
   parameter int ADDR_W = 3
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   output logic [7:0] rd_data,
   input wire logic sync_clock_line,
   input wire logic sync_data_line_in,
   output logic sync_data_line_out,
   output logic sync_data_line_oe,
   output logic tx_wake,
   output logic rx_wake
);
   if (ADDR_W < 3)
   begin : g_bad_addr
      $error("ADDR_W must be at least 3");
   end

   ssp_pkg::ssp_txctl_t txctl;
   ssp_pkg::ssp_rxctl_t rxctl;
   ssp_pkg::ssp_tx_state_t tx_state;
   logic [7:0] tx_buffer;
   logic tx_buf_full;
   logic [8:0] tx_shifter;
   logic [3:0] tx_cnt;
   logic [8:0] rx_shifter;
   logic [3:0] rx_cnt;
   logic [7:0] rx_buffer;
   logic rx_ninth_bit;
   logic rx_done_flag;
   logic overrun_error;
   logic [7:0] baud_divisor;
   logic [1:0] irq_en;
   logic [1:0] irq_prio;
   logic [2:0] ck_sync;
   logic [1:0] dt_sync;
   logic link_fall;
   logic sel_hi;
   logic [2:0] reg_sel;
   logic wr_hit;
   logic tx_buf_wr;
   logic rx_buf_rd;
   logic slave_mode;
   logic tx_on;
   logic rx_on;
   logic tx_load;
   logic tx_last;
   logic rx_last;
   logic rx_word_done;
   logic [8:0] rx_word;
   logic tx_buf_empty_flag;
   logic tx_shifter_empty;
   logic [3:0] tx_len;
   logic [3:0] rx_len;

   assign sel_hi = (ADDR_W > 3) ? (addr >> 3) != '0 : 1'b0;
   assign reg_sel = addr[2:0];
   assign wr_hit = ce && wr_strobe && !sel_hi;
   assign tx_buf_wr = wr_hit && reg_sel == ssp_pkg::OFS_TX_BUF;
   assign rx_buf_rd = ce && rd_strobe && !sel_hi && reg_sel == ssp_pkg::OFS_RX_BUF;

   // Sync slave mode: external clock, port enabled
   assign slave_mode = rxctl.port_enable && txctl.sync_mode && !txctl.clock_source_select;
   // Half duplex: continuous receive owns the data line, single receive is a don't care
   assign rx_on = slave_mode && rxctl.continuous_rx_enable;
   assign tx_on = slave_mode && txctl.tx_enable && !rxctl.continuous_rx_enable;
   assign tx_len = txctl.tx_nine_bit_select ? ssp_pkg::WORD_BITS_9 : ssp_pkg::WORD_BITS_8;
   assign rx_len = rxctl.rx_nine_bit_select ? ssp_pkg::WORD_BITS_9 : ssp_pkg::WORD_BITS_8;
   assign tx_buf_empty_flag = !tx_buf_full;
   assign tx_shifter_empty = tx_state == ssp_pkg::SSP_TX_IDLE;

   // Clock pin passes three flops, data pin two; edges are found on the second and third stage only
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ck_sync <= 3'h0;
         dt_sync <= 2'h0;
      end
      else if (ce)
      begin
         ck_sync <= {ck_sync[1:0], sync_clock_line};
         dt_sync <= {dt_sync[0], sync_data_line_in};
      end
   end
   // The clock comes only from the master and is never driven here
   assign link_fall = ck_sync[2] && !ck_sync[1];

   // Register writes
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         txctl <= ssp_pkg::RST_TXCTL;
         rxctl <= ssp_pkg::RST_RXCTL;
         baud_divisor <= ssp_pkg::RST_BYTE;
         irq_en <= 2'h0;
         irq_prio <= 2'h0;
      end
      else if (wr_hit)
      begin
         case (reg_sel)
            ssp_pkg::OFS_TX_CTL:
            begin
               txctl.clock_source_select <= wr_data[ssp_pkg::TX_CLK_SRC_B];
               txctl.tx_nine_bit_select <= wr_data[ssp_pkg::TX_NINE_B];
               txctl.tx_enable <= wr_data[ssp_pkg::TX_EN_B];
               txctl.sync_mode <= wr_data[ssp_pkg::TX_SYNC_B];
               txctl.high_baud_select <= wr_data[ssp_pkg::TX_HIGH_BAUD_B];
               txctl.tx_ninth_bit <= wr_data[ssp_pkg::TX_NINTH_B];
            end
            ssp_pkg::OFS_RX_CTL:
            begin
               rxctl.port_enable <= wr_data[ssp_pkg::RX_PORT_EN_B];
               rxctl.rx_nine_bit_select <= wr_data[ssp_pkg::RX_NINE_B];
               rxctl.single_rx_enable <= wr_data[ssp_pkg::RX_SINGLE_B];
               rxctl.continuous_rx_enable <= wr_data[ssp_pkg::RX_CONT_B];
               rxctl.address_detect_enable <= wr_data[ssp_pkg::RX_ADDR_DET_B];
            end
            // Stored for software only; slave timing never uses it
            ssp_pkg::OFS_BAUD: baud_divisor <= wr_data;
            ssp_pkg::OFS_ENABLES: irq_en <= {wr_data[ssp_pkg::IRQ_RX_B], wr_data[ssp_pkg::IRQ_TX_B]};
            ssp_pkg::OFS_PRIO: irq_prio <= {wr_data[ssp_pkg::IRQ_RX_B], wr_data[ssp_pkg::IRQ_TX_B]};
            default: ;
         endcase
      end
   end

   // Transmit buffer; a write in the load cycle wins and keeps the buffer full
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_buffer <= ssp_pkg::RST_BYTE;
         tx_buf_full <= 1'b0;
      end
      else if (ce)
      begin
         if (tx_buf_wr)
         begin
            tx_buffer <= wr_data;
            tx_buf_full <= 1'b1;
         end
         else if (tx_load)
            tx_buf_full <= 1'b0;
      end
   end

   assign tx_last = link_fall && tx_cnt == tx_len - 4'h1;
   // Load as soon as the shifter is idle, also between back-to-back words
   assign tx_load = tx_on && tx_buf_full && tx_state == ssp_pkg::SSP_TX_IDLE;

   // Transmit shifter: one bit per falling link edge, LSB first
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_state <= ssp_pkg::SSP_TX_IDLE;
         tx_shifter <= 9'h1FF;
         tx_cnt <= 4'h0;
      end
      else if (ce)
      begin
         case (tx_state)
            ssp_pkg::SSP_TX_IDLE:
            begin
               if (tx_load)
               begin
                  tx_shifter <= {txctl.tx_ninth_bit, tx_buffer};
                  tx_cnt <= 4'h0;
                  tx_state <= ssp_pkg::SSP_TX_SHIFT;
               end
            end
            ssp_pkg::SSP_TX_SHIFT:
            begin
               if (!tx_on)
                  tx_state <= ssp_pkg::SSP_TX_IDLE;
               else if (link_fall)
               begin
                  tx_shifter <= {1'b1, tx_shifter[8:1]};
                  tx_cnt <= tx_cnt + 4'h1;
                  if (tx_last)
                     tx_state <= ssp_pkg::SSP_TX_IDLE;
               end
            end
            default: tx_state <= ssp_pkg::SSP_TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_data_line_out <= 1'b1;
         sync_data_line_oe <= 1'b0;
      end
      else if (ce)
      begin
         sync_data_line_out <= tx_state == ssp_pkg::SSP_TX_SHIFT ? tx_shifter[0] : 1'b1;
         sync_data_line_oe <= tx_on;
      end
   end

   // Receive shifter; like every other register here it holds while ce is low
   assign rx_word = {dt_sync[1], rx_shifter[8:1]};
   assign rx_last = rx_cnt == rx_len - 4'h1;
   assign rx_word_done = rx_on && link_fall && rx_last;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_shifter <= 9'h000;
         rx_cnt <= 4'h0;
      end
      else if (ce)
      begin
         if (!rx_on)
            rx_cnt <= 4'h0;
         else if (link_fall)
         begin
            rx_shifter <= rx_word;
            rx_cnt <= rx_last ? 4'h0 : rx_cnt + 4'h1;
         end
      end
   end

   // Receive buffer, done flag and overrun; a completion beats a same-cycle read
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_buffer <= ssp_pkg::RST_BYTE;
         rx_ninth_bit <= 1'b0;
         rx_done_flag <= 1'b0;
         overrun_error <= 1'b0;
      end
      else if (ce)
      begin
         if (rx_word_done && rx_done_flag && !rx_buf_rd)
            overrun_error <= 1'b1;
         else if (!rxctl.continuous_rx_enable)
            overrun_error <= 1'b0;
         if (rx_word_done && !overrun_error && !(rx_done_flag && !rx_buf_rd))
         begin
            rx_buffer <= rxctl.rx_nine_bit_select ? rx_word[7:0] : rx_word[8:1];
            rx_ninth_bit <= rxctl.rx_nine_bit_select && rx_word[8];
            rx_done_flag <= 1'b1;
         end
         else if (rx_buf_rd)
            rx_done_flag <= 1'b0;
      end
   end

   // Wake requests follow flag and enable; priority bits only steer the host side
   assign tx_wake = tx_buf_empty_flag && irq_en[0];
   assign rx_wake = rx_done_flag && irq_en[1];

   // Read data one cycle after the strobe; status must be read before the byte
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rd_data <= 8'h00;
      else if (ce && rd_strobe)
      begin
         rd_data <= 8'h00;
         if (!sel_hi)
         begin
            case (reg_sel)
               ssp_pkg::OFS_TX_CTL: rd_data <= {txctl.clock_source_select, txctl.tx_nine_bit_select,
                  txctl.tx_enable, txctl.sync_mode, 1'b0, txctl.high_baud_select,
                  tx_shifter_empty, txctl.tx_ninth_bit};
               ssp_pkg::OFS_RX_CTL: rd_data <= {rxctl.port_enable, rxctl.rx_nine_bit_select,
                  rxctl.single_rx_enable, rxctl.continuous_rx_enable, rxctl.address_detect_enable,
                  1'b0, overrun_error, rx_ninth_bit};
               ssp_pkg::OFS_TX_BUF: rd_data <= tx_buffer;
               ssp_pkg::OFS_RX_BUF: rd_data <= rx_buffer;
               ssp_pkg::OFS_BAUD: rd_data <= baud_divisor;
               ssp_pkg::OFS_FLAGS: rd_data <= {2'h0, rx_done_flag, tx_buf_empty_flag, 4'h0};
               ssp_pkg::OFS_ENABLES: rd_data <= {2'h0, irq_en, 4'h0};
               ssp_pkg::OFS_PRIO: rd_data <= {2'h0, irq_prio, 4'h0};
               default: rd_data <= 8'h00;
            endcase
         end
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   property p_buf_wr_clears_flag;
      tx_buf_wr |=> !tx_buf_empty_flag;
   endproperty
   a_buf_wr_clears_flag: assert property (p_buf_wr_clears_flag) else $error("buffer write kept empty flag");

   property p_flag_sets_on_load;
      $rose(tx_buf_empty_flag) |-> $past(tx_load) && $past(ce);
   endproperty
   a_flag_sets_on_load: assert property (p_flag_sets_on_load) else $error("empty flag set without load");

   property p_load_busies_shifter;
      tx_load && ce |=> !tx_shifter_empty ##0 tx_shifter[7:0] == $past(tx_buffer);
   endproperty
   a_load_busies_shifter: assert property (p_load_busies_shifter) else $error("load did not fill shifter");

   property p_second_word_held;
      tx_state == ssp_pkg::SSP_TX_SHIFT && tx_buf_full && !tx_last && ce |=> tx_buf_full;
   endproperty
   a_second_word_held: assert property (p_second_word_held) else $error("queued word lost early");

   property p_rx_to_buffer;
      rx_word_done && ce && !rx_done_flag && !overrun_error && !rxctl.rx_nine_bit_select
         |=> rx_done_flag && rx_buffer == $past(rx_word[8:1]);
   endproperty
   a_rx_to_buffer: assert property (p_rx_to_buffer) else $error("received word not buffered");

   property p_rx_sets_flag;
      rx_word_done && ce && !overrun_error |=> rx_done_flag;
   endproperty
   a_rx_sets_flag: assert property (p_rx_sets_flag) else $error("receive flag not set");

   property p_err_clear;
      ce && !rxctl.continuous_rx_enable |=> !overrun_error;
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("overrun survived receive disable");

   property p_no_drive_in_rx;
      rx_on && ce |=> !sync_data_line_oe;
   endproperty
   a_no_drive_in_rx: assert property (p_no_drive_in_rx) else $error("data driven while receiving");

   property p_shift_on_link_edge;
      ce && tx_state == ssp_pkg::SSP_TX_SHIFT && !link_fall |=> $stable(tx_cnt);
   endproperty
   a_shift_on_link_edge: assert property (p_shift_on_link_edge) else $error("shift without link edge");

   property p_tx_wake;
      $rose(tx_buf_empty_flag) && irq_en[0] |-> tx_wake;
   endproperty
   a_tx_wake: assert property (p_tx_wake) else $error("no transmit wake");

   property p_rx_wake;
      $rose(rx_done_flag) && irq_en[1] |-> rx_wake;
   endproperty
   a_rx_wake: assert property (p_rx_wake) else $error("no receive wake");
endmodule : ssp_slave
`default_nettype wire

// file: ssp_slave_test.sv
// Self-checking bench for the synchronous slave serial port
`timescale 1ns/10ps
`default_nettype none
module ssp_slave_test;
   typedef struct packed {
      logic wr;
      logic [3:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } ssp_row_t;
   localparam logic [3:0] A_TXC = {1'b0, ssp_pkg::OFS_TX_CTL};
   localparam logic [3:0] A_RXC = {1'b0, ssp_pkg::OFS_RX_CTL};
   localparam logic [3:0] A_TXB = {1'b0, ssp_pkg::OFS_TX_BUF};
   localparam logic [3:0] A_RXB = {1'b0, ssp_pkg::OFS_RX_BUF};
   localparam logic [3:0] A_BAUD = {1'b0, ssp_pkg::OFS_BAUD};
   localparam logic [3:0] A_FLG = {1'b0, ssp_pkg::OFS_FLAGS};
   localparam logic [3:0] A_EN = {1'b0, ssp_pkg::OFS_ENABLES};
   localparam logic [3:0] A_PRI = {1'b0, ssp_pkg::OFS_PRIO};
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wr_data = 8'h00;
   logic wr_strobe = 1'b0;
   logic rd_strobe = 1'b0;
   logic ce = 1'b1;
   logic [7:0] rd_data;
   logic sync_clock_line, data_drive, data_out, data_oe, tx_wake, rx_wake;
   logic [8:0] got;
   int n_mismatch = 0;
   int checked = 0;
   // Address 9 lies beyond the map; an aliasing decoder would hit the receive control
   ssp_row_t rows [9] = '{
      '{1'b0, A_TXC, 8'h00, 8'h02}, '{1'b0, A_RXC, 8'h00, 8'h00}, '{1'b0, A_FLG, 8'h00, 8'h10},
      '{1'b1, A_BAUD, 8'hA5, 8'hA5}, '{1'b1, A_PRI, 8'hFF, 8'h30}, '{1'b1, A_FLG, 8'h00, 8'h10},
      '{1'b1, A_RXB, 8'h5A, 8'h00}, '{1'b1, 4'h9, 8'h55, 8'h00}, '{1'b0, A_RXC, 8'h00, 8'h00}};
   wire logic data_wire = data_oe ? data_out : data_drive;

   always #12.5 clk_sys = ~clk_sys;

   ssp_slave #(.ADDR_W(4)) DUT (
      .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .addr(addr), .wr_data(wr_data),
      .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
      .sync_clock_line(sync_clock_line), .sync_data_line_in(data_wire),
      .sync_data_line_out(data_out), .sync_data_line_oe(data_oe), .tx_wake(tx_wake), .rx_wake(rx_wake)
   );
   ssp_master_model master (
      .sync_clock_line(sync_clock_line), .data_drive(data_drive), .data_wire(data_wire)
   );

   task automatic expect_eq(input logic [8:0] got_v, input logic [8:0] exp_v);
      checked++;
      if (got_v !== exp_v)
      begin
         n_mismatch++;
         $display("BAD at %0t: got %h expected %h", $time, got_v, exp_v);
      end
   endtask : expect_eq
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wr_data <= d;
      wr_strobe <= 1'b1;
      @(posedge clk_sys);
      wr_strobe <= 1'b0;
   endtask : reg_wr
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      addr <= a;
      rd_strobe <= 1'b1;
      @(posedge clk_sys);
      rd_strobe <= 1'b0;
      #1 expect_eq({1'b0, rd_data}, {1'b0, e});
   endtask : rd_chk
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   initial
   begin
      #1_000_000;
      n_mismatch++;
      finish_test();
   end

   initial
   begin
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      foreach (rows[i])
      begin
         if (rows[i].wr)
            reg_wr(rows[i].a, rows[i].d);
         rd_chk(rows[i].a, rows[i].e);
      end
      // Clock enable low freezes the registers, so this write must not land
      @(posedge clk_sys);
      ce <= 1'b0;
      reg_wr(A_BAUD, 8'h3C);
      ce <= 1'b1;
      rd_chk(A_BAUD, 8'hA5);
      // Transmit: receive enables stay clear because the link is half-duplex
      reg_wr(A_RXC, 8'h80);
      reg_wr(A_EN, 8'h10);
      #1 expect_eq({8'h00, tx_wake}, 9'h001);
      reg_wr(A_TXC, 8'h30);
      reg_wr(A_TXB, 8'hA7);
      repeat (4) @(posedge clk_sys);
      reg_wr(A_TXB, 8'h4C);
      rd_chk(A_FLG, 8'h00);
      expect_eq({8'h00, tx_wake}, 9'h000);
      rd_chk(A_TXC, 8'h30);
      master.recv_word(8, got);
      expect_eq(got, 9'h0A7);
      repeat (6) @(posedge clk_sys);
      rd_chk(A_FLG, 8'h10);
      expect_eq({8'h00, tx_wake}, 9'h001);
      master.recv_word(8, got);
      expect_eq(got, 9'h04C);
      repeat (6) @(posedge clk_sys);
      rd_chk(A_TXC, 8'h32);
      reg_wr(A_TXC, 8'h71);
      reg_wr(A_TXB, 8'h96);
      repeat (4) @(posedge clk_sys);
      master.recv_word(9, got);
      expect_eq(got, 9'h196);
      // Receive with the interrupt enable set
      reg_wr(A_TXC, 8'h10);
      reg_wr(A_EN, 8'h20);
      reg_wr(A_RXC, 8'h90);
      master.send_word(9'h03C, 8);
      repeat (6) @(posedge clk_sys);
      expect_eq({8'h00, rx_wake}, 9'h001);
      rd_chk(A_RXC, 8'h90);
      rd_chk(A_RXB, 8'h3C);
      expect_eq({8'h00, rx_wake}, 9'h000);
      // Second word arrives while the first is unread and is dropped as an overrun
      master.send_word(9'h011, 8);
      master.send_word(9'h022, 8);
      repeat (6) @(posedge clk_sys);
      rd_chk(A_RXC, 8'h92);
      reg_wr(A_RXC, 8'h80);
      rd_chk(A_RXC, 8'h80);
      rd_chk(A_RXB, 8'h11);
      // Single-word enable set too; it must change nothing
      reg_wr(A_RXC, 8'hF0);
      master.send_word(9'h1C3, 9);
      repeat (6) @(posedge clk_sys);
      rd_chk(A_RXC, 8'hF1);
      rd_chk(A_RXB, 8'hC3);
      // Leave a word pending so that reset has a wake request to remove
      master.send_word(9'h0AA, 9);
      repeat (6) @(posedge clk_sys);
      expect_eq({8'h00, rx_wake}, 9'h001);
      // Reset in mid-run
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      expect_eq({7'h00, data_oe, rx_wake}, 9'h000);
      rst_n <= 1'b1;
      rd_chk(A_FLG, 8'h10);
      rd_chk(A_TXC, 8'h02);
      rd_chk(A_RXC, 8'h00);
      // Internal clock source selected: the slave path must not load or drive
      reg_wr(A_RXC, 8'h80);
      reg_wr(A_TXC, 8'hB0);
      reg_wr(A_TXB, 8'h5A);
      repeat (4) @(posedge clk_sys);
      rd_chk(A_FLG, 8'h00);
      expect_eq({8'h00, data_oe}, 9'h000);
      finish_test();
   end
endmodule : ssp_slave_test
`default_nettype wire
